// ===== core/fspc_top.sv
`timescale 1ns/10ps
module fspc_top
  import fspc_pkg::*;
#(
  parameter int FLASH_WORDS = 8192,
  parameter int CFG_WORDS   = 1024,
  parameter int WP_LIMIT    = 0,
  parameter logic [13:0] DEVICE_ID = 14'h1234
)(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Reset-during-write indication from the power controller
  input  wire logic        resetDuringWrite,
  // Interrupt
  output logic             irq
);
  localparam int AW = $clog2(FLASH_WORDS);
  localparam int CW = $clog2(CFG_WORDS);
  localparam int CNTW = $clog2(FSPC_WRITE_CYCLES + 1);

  logic [7:0]  dataLow_q;
  logic [5:0]  dataHigh_q;
  logic [7:0]  addrLow_q;
  logic [6:0]  addrHigh_q;
  logic        cfgSel_q;
  logic        latchOnly_q;
  logic        rowErase_q;
  logic        errFlag_q;
  logic        progEnable_q;
  logic        writeStart_q;
  logic        readStart_q;
  logic [1:0]  irqStatus_q;
  logic [1:0]  irqMask_q;
  logic        ack_q;
  logic [31:0] rdData_q;
  fspc_state_t state_q;
  logic [CNTW-1:0] busyCnt_q;
  logic [4:0]  rowIdx_q;
  logic        opDone;
  logic        rdDone;
  logic        rstWrSync1_q;
  logic        rstWrSync2_q;

  logic [13:0] flashMem [FLASH_WORDS];
  logic [13:0] cfgMem   [CFG_WORDS];
  logic [13:0] latches  [FSPC_ROW_WORDS];

  wire logic [14:0] wordAddr = {addrHigh_q, addrLow_q};
  wire logic [13:0] dataWord = {dataHigh_q, dataLow_q};
  wire logic [AW-1:0] flashIdx = wordAddr[AW-1:0];
  wire logic [CW-1:0] cfgIdx = wordAddr[CW-1:0];
  wire logic [AW-1:0] rowBase = {flashIdx[AW-1:5], 5'h00};

  // Bus decode
  wire logic busReq = cyc_i & stb_i & ~ack_q;
  wire logic busWr  = busReq & we_i & sel_i[0];
  wire logic busRd  = busReq & ~we_i;
  wire logic wrCtl  = busWr & (adr_i == FSPC_OFS_CONTROL);
  wire logic wrKey  = busWr & (adr_i == FSPC_OFS_UNLOCK);
  wire logic busy   = (state_q != FSPC_IDLE);

  // Protection and config-space write window
  wire logic cfgWritable = (wordAddr <= FSPC_UID_LAST);
  wire logic protectedAddr = cfgSel_q ? ~cfgWritable
                                      : (32'(wordAddr) < 32'(WP_LIMIT));
  wire logic cfgReadable = (wordAddr <= FSPC_UID_LAST)
                         | ((wordAddr >= FSPC_DEV_FIRST) & (wordAddr <= FSPC_CFG_LAST))
                         | ((wordAddr >= FSPC_DIA_FIRST) & (wordAddr <= FSPC_DIA_LAST));

  logic unlocked;
  logic unlockBroken;
  wire logic startTry = wrCtl & dat_i[FSPC_CTL_WR] & ~writeStart_q;
  wire logic startOk  = startTry & unlocked & progEnable_q & ~busy;

  fspc_unlock u_unlock (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .clkEn      (clkEn),
    .keyWrite   (wrKey),
    .keyData    (dat_i[7:0]),
    .otherWrite (busWr & ~wrKey),
    .startTry   (startTry),
    .unlocked   (unlocked),
    .broken     (unlockBroken)
  );

  // Reset-during-write input comes from another domain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rstWrSync1_q <= 1'b0;
      rstWrSync2_q <= 1'b0;
    end else if (clkEn) begin
      rstWrSync1_q <= resetDuringWrite;
      rstWrSync2_q <= rstWrSync1_q;
    end
  end

  // Operation sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= FSPC_IDLE;
      busyCnt_q <= '0;
      rowIdx_q  <= 5'h00;
    end else if (clkEn) begin
      case (state_q)
        FSPC_IDLE: begin
          if (busWr && adr_i == FSPC_OFS_CONTROL && dat_i[FSPC_CTL_RD] && !readStart_q) begin
            state_q <= FSPC_READ;
          end else if (startOk && !(dat_i[FSPC_CTL_FREE] == 1'b0 && latchOnly_q)
                       && protectedAddr) begin
            state_q <= FSPC_IDLE;
          end else if (startOk) begin
            busyCnt_q <= CNTW'(FSPC_WRITE_CYCLES);
            rowIdx_q  <= 5'h00;
            if (dat_i[FSPC_CTL_FREE] || rowErase_q) begin
              state_q <= FSPC_ERASE;
            end else if (latchOnly_q) begin
              state_q <= FSPC_FILL;
            end else begin
              state_q <= FSPC_PROG;
            end
          end
        end
        FSPC_READ: state_q <= FSPC_IDLE;
        FSPC_FILL: state_q <= FSPC_IDLE;
        FSPC_ERASE, FSPC_PROG: begin
          // Self-timed; a cleared start bit does not stop it
          rowIdx_q <= rowIdx_q + 5'd1;
          if (busyCnt_q <= CNTW'(1)) begin
            state_q <= FSPC_IDLE;
          end else begin
            busyCnt_q <= busyCnt_q - CNTW'(1);
          end
        end
        default: state_q <= FSPC_IDLE;
      endcase
    end
  end

  assign opDone = clkEn & ((state_q == FSPC_ERASE) | (state_q == FSPC_PROG)
                           | (state_q == FSPC_FILL)) & ((state_q == FSPC_FILL)
                           | (busyCnt_q <= CNTW'(1)));
  assign rdDone = clkEn & (state_q == FSPC_READ);

  // Memory arrays
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (state_q == FSPC_FILL) begin
        latches[wordAddr[4:0]] <= dataWord;
      end else if (state_q == FSPC_ERASE) begin
        if (cfgSel_q) begin
          cfgMem[{cfgIdx[CW-1:5], rowIdx_q}] <= FSPC_BLANK_WORD;
        end else begin
          flashMem[rowBase | AW'(rowIdx_q)] <= FSPC_BLANK_WORD;
        end
        latches[rowIdx_q] <= FSPC_BLANK_WORD;
      end else if (state_q == FSPC_PROG) begin
        // Flash programming only clears bits
        if (cfgSel_q) begin
          cfgMem[{cfgIdx[CW-1:5], rowIdx_q}] <=
            cfgMem[{cfgIdx[CW-1:5], rowIdx_q}] & latches[rowIdx_q];
        end else begin
          flashMem[rowBase | AW'(rowIdx_q)] <=
            flashMem[rowBase | AW'(rowIdx_q)] & latches[rowIdx_q];
        end
        latches[rowIdx_q] <= FSPC_BLANK_WORD;
      end
    end
  end

  // Data pair: bus writes and read results
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dataLow_q  <= 8'h00;
      dataHigh_q <= 6'h00;
    end else if (clkEn) begin
      if (rdDone) begin
        if (!cfgSel_q) begin
          {dataHigh_q, dataLow_q} <= flashMem[flashIdx];
        end else if (!cfgReadable) begin
          {dataHigh_q, dataLow_q} <= 14'h0000;
        end else if (wordAddr == FSPC_DEV_FIRST) begin
          {dataHigh_q, dataLow_q} <= DEVICE_ID;
        end else begin
          {dataHigh_q, dataLow_q} <= cfgMem[cfgIdx];
        end
      end else if (busWr && adr_i == FSPC_OFS_DATA_LOW) begin
        dataLow_q <= dat_i[7:0];
      end else if (busWr && adr_i == FSPC_OFS_DATA_HIGH) begin
        dataHigh_q <= dat_i[5:0];
      end
    end
  end

  // Address pair
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addrLow_q  <= FSPC_ADDR_LOW_RST;
      addrHigh_q <= FSPC_ADDR_HIGH_RST;
    end else if (clkEn) begin
      if (busWr && adr_i == FSPC_OFS_ADDR_LOW) begin
        addrLow_q <= dat_i[7:0];
      end
      if (busWr && adr_i == FSPC_OFS_ADDR_HIGH) begin
        addrHigh_q <= dat_i[6:0];
      end
    end
  end

  // Control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfgSel_q     <= 1'b0;
      latchOnly_q  <= 1'b0;
      rowErase_q   <= 1'b0;
      progEnable_q <= 1'b0;
      writeStart_q <= 1'b0;
      readStart_q  <= 1'b0;
    end else if (clkEn) begin
      if (wrCtl) begin
        cfgSel_q     <= dat_i[FSPC_CTL_REGS];
        latchOnly_q  <= dat_i[FSPC_CTL_LATCH_ONLY_LOAD];
        progEnable_q <= dat_i[FSPC_CTL_PROGRAM_ENABLE_GATE];
        if (!busy) begin
          rowErase_q <= dat_i[FSPC_CTL_FREE];
        end
      end
      // Start bits only settable; hardware clears them
      if (startOk && !(protectedAddr && !(latchOnly_q && !dat_i[FSPC_CTL_FREE]))) begin
        writeStart_q <= 1'b1;
      end else if (opDone) begin
        writeStart_q <= 1'b0;
        if (state_q == FSPC_ERASE) begin
          rowErase_q <= 1'b0;
        end
      end
      if (wrCtl && dat_i[FSPC_CTL_RD] && !busy) begin
        readStart_q <= 1'b1;
      end else if (rdDone) begin
        readStart_q <= 1'b0;
      end
    end
  end

  // Error flag: hardware set wins over software clear
  wire logic protFault = startOk & protectedAddr
                       & ~(latchOnly_q & ~dat_i[FSPC_CTL_FREE]);
  wire logic errEvent = protFault | unlockBroken | (rstWrSync2_q & busy);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errFlag_q <= 1'b0;
    end else if (clkEn) begin
      if (errEvent) begin
        errFlag_q <= 1'b1;
      end else if (wrCtl) begin
        errFlag_q <= dat_i[FSPC_CTL_ERR];
      end
    end
  end

  // Interrupt status: read clears, new event wins
  wire logic rdStatus = busRd & (adr_i == FSPC_OFS_IRQ_STATUS);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStatus_q <= 2'b00;
      irqMask_q   <= 2'b00;
    end else if (clkEn) begin
      irqStatus_q <= (rdStatus ? 2'b00 : irqStatus_q)
                   | {errEvent, opDone & (state_q != FSPC_FILL)};
      if (busWr && adr_i == FSPC_OFS_IRQ_MASK) begin
        irqMask_q <= dat_i[1:0];
      end
    end
  end

  assign irq = |(irqStatus_q & irqMask_q);

  // Read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (adr_i)
      FSPC_OFS_DATA_LOW:   rdMux = {24'h000000, dataLow_q};
      FSPC_OFS_DATA_HIGH:  rdMux = {24'h000000, 2'b00, dataHigh_q};
      FSPC_OFS_ADDR_LOW:   rdMux = {24'h000000, addrLow_q};
      // Top bit reads one; stays one during a write too
      FSPC_OFS_ADDR_HIGH:  rdMux = {24'h000000, 1'b1, addrHigh_q};
      FSPC_OFS_CONTROL:    rdMux = {24'h000000, 1'b0, cfgSel_q, latchOnly_q, rowErase_q,
                                    errFlag_q, progEnable_q, writeStart_q, readStart_q};
      FSPC_OFS_IRQ_STATUS: rdMux = {30'h00000000, irqStatus_q};
      FSPC_OFS_IRQ_MASK:   rdMux = {30'h00000000, irqMask_q};
      default:             rdMux = 32'h0000_0000;
    endcase
  end

  // One wait-free ack per request; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end else if (clkEn) begin
      ack_q    <= busReq;
      rdData_q <= busRd ? rdMux : 32'h0000_0000;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdData_q;
endmodule

// ===== core/fspc_pkg.sv
package fspc_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [4:0] FSPC_OFS_DATA_LOW   = 5'h00;
  localparam logic [4:0] FSPC_OFS_DATA_HIGH  = 5'h04;
  localparam logic [4:0] FSPC_OFS_ADDR_LOW   = 5'h08;
  localparam logic [4:0] FSPC_OFS_ADDR_HIGH  = 5'h0C;
  localparam logic [4:0] FSPC_OFS_CONTROL    = 5'h10;
  localparam logic [4:0] FSPC_OFS_UNLOCK     = 5'h14;
  localparam logic [4:0] FSPC_OFS_IRQ_STATUS = 5'h18;
  localparam logic [4:0] FSPC_OFS_IRQ_MASK   = 5'h1C;

  // Control register bit positions
  localparam int FSPC_CTL_RD   = 0;
  localparam int FSPC_CTL_WR   = 1;
  localparam int FSPC_CTL_PROGRAM_ENABLE_GATE = 2;
  localparam int FSPC_CTL_ERR  = 3;
  localparam int FSPC_CTL_FREE = 4;
  localparam int FSPC_CTL_LATCH_ONLY_LOAD = 5;
  localparam int FSPC_CTL_REGS = 6;

  // Interrupt status bit positions
  localparam int FSPC_IRQ_DONE = 0;
  localparam int FSPC_IRQ_ERR  = 1;

  // Unlock key bytes
  localparam logic [7:0] FSPC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] FSPC_KEY_SECOND = 8'hAA;

  // Reset values and erased-word value
  localparam logic [7:0]  FSPC_ADDR_LOW_RST = 8'h00;
  localparam logic [6:0]  FSPC_ADDR_HIGH_RST = 7'h00;
  localparam logic [13:0] FSPC_BLANK_WORD   = 14'h3FFF;

  // Timing
  localparam int FSPC_CLK_MHZ        = 40;
  localparam int FSPC_WRITE_TIME_US  = 2;
  localparam int FSPC_WRITE_CYCLES   = FSPC_WRITE_TIME_US * FSPC_CLK_MHZ;
  localparam int FSPC_ROW_WORDS      = 32;

  // Config-space windows (word address, bit 15 implied by select)
  localparam logic [14:0] FSPC_UID_LAST  = 15'h0003;
  localparam logic [14:0] FSPC_DEV_FIRST = 15'h0005;
  localparam logic [14:0] FSPC_CFG_LAST  = 15'h000B;
  localparam logic [14:0] FSPC_DIA_FIRST = 15'h0100;
  localparam logic [14:0] FSPC_DIA_LAST  = 15'h02FF;

  typedef enum logic [2:0] {
    FSPC_IDLE  = 3'b000,
    FSPC_READ  = 3'b001,
    FSPC_ERASE = 3'b010,
    FSPC_PROG  = 3'b011,
    FSPC_FILL  = 3'b100
  } fspc_state_t;

endpackage

// ===== core/fspc_unlock.sv
`timescale 1ns/10ps
module fspc_unlock
  import fspc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clkEn,
  // Key writes
  input  wire logic       keyWrite,
  input  wire logic [7:0] keyData,
  // Other register writes break the sequence
  input  wire logic       otherWrite,
  // Consume on start attempt
  input  wire logic       startTry,
  // Status
  output logic            unlocked,
  output logic            broken
);
  logic [1:0] step_q;

  assign unlocked = (step_q == 2'd2);

  // Only an immediate 55h then AAh arms the start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_q <= 2'd0;
      broken <= 1'b0;
    end else if (clkEn) begin
      broken <= 1'b0;
      if (startTry) begin
        step_q <= 2'd0;
      end else if (keyWrite) begin
        if (step_q == 2'd0 && keyData == FSPC_KEY_FIRST) begin
          step_q <= 2'd1;
        end else if (step_q == 2'd1 && keyData == FSPC_KEY_SECOND) begin
          step_q <= 2'd2;
        end else begin
          step_q <= 2'd0;
          broken <= (step_q != 2'd0);
        end
      end else if (otherWrite && step_q != 2'd0) begin
        step_q <= 2'd0;
        broken <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/fspc_top_props.sv
`timescale 1ns/10ps
module fspc_top_props
  import fspc_pkg::*;
#(
  parameter int          FLASH_WORDS = 8192,
  parameter int          CFG_WORDS   = 1024,
  parameter int          WP_LIMIT    = 0,
  parameter logic [13:0] DEVICE_ID   = 14'h1234
)(
  // Clock, reset, enable
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clkEn,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Misc
  input wire logic        resetDuringWrite,
  input wire logic        irq
);
  logic [7:0] adrLowQ;
  logic [6:0] adrHighQ;
  logic [1:0] maskQ;
  logic [2:0] rdWaitQ;
  logic       errQ;
  // Shadows follow the edge at which the design takes a write
  wire logic  wrAck = cyc_i && stb_i && !ack_o && clkEn && we_i && sel_i[0];
  wire logic  rdAck = ack_o && clkEn && !we_i;
  wire logic  ctlHit = adr_i == FSPC_OFS_CONTROL;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Shadows of registers only software changes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adrLowQ  <= 8'h00;
      adrHighQ <= 7'h00;
      maskQ    <= 2'h0;
    end else if (wrAck) begin
      if (adr_i == FSPC_OFS_ADDR_LOW) adrLowQ <= dat_i[7:0];
      if (adr_i == FSPC_OFS_ADDR_HIGH) adrHighQ <= dat_i[6:0];
      if (adr_i == FSPC_OFS_IRQ_MASK) maskQ <= dat_i[1:0];
    end
  end

  // Load takes one cycle; margin of three more
  always_ff @(posedge clk_sys) begin
    if (rst) rdWaitQ <= 3'h0;
    else if (wrAck && ctlHit && dat_i[FSPC_CTL_RD]) rdWaitQ <= 3'h4;
    else if (rdWaitQ != 3'h0) rdWaitQ <= rdWaitQ - 3'h1;
  end

  // Error once seen must persist until written clear
  always_ff @(posedge clk_sys) begin
    if (rst) errQ <= 1'b0;
    else if (wrAck && ctlHit && !dat_i[FSPC_CTL_ERR]) errQ <= 1'b0;
    else if (rdAck && ctlHit && dat_o[FSPC_CTL_ERR]) errQ <= 1'b1;
  end

  sequence s_req;
    cyc_i && stb_i && !ack_o && clkEn;
  endsequence
  sequence s_reply;
    ack_o ##1 !ack_o;
  endsequence

  property p_ack_next;
    s_req |=> s_reply;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack not one pulse after request");
  property p_reset_quiet;
    $fell(rst) |-> !ack_o && !irq && dat_o == 32'h0000_0000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_data_high;
    rdAck && adr_i == FSPC_OFS_DATA_HIGH |-> dat_o[7:6] == 2'b00;
  endproperty
  a_data_high: assert property (p_data_high)
    else $error("data high top bits not zero");
  property p_addr_low;
    rdAck && adr_i == FSPC_OFS_ADDR_LOW |-> dat_o[7:0] == adrLowQ;
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("address low readback wrong");
  property p_addr_high;
    rdAck && adr_i == FSPC_OFS_ADDR_HIGH |-> dat_o[7:0] == {1'b1, adrHighQ};
  endproperty
  a_addr_high: assert property (p_addr_high)
    else $error("address high readback wrong");
  property p_rd_clear;
    rdAck && ctlHit && rdWaitQ == 3'h0 |-> !dat_o[FSPC_CTL_RD];
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read start did not clear");
  property p_err_sticky;
    rdAck && ctlHit && errQ |-> dat_o[FSPC_CTL_ERR];
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag lost without software clear");
  property p_irq_mask;
    maskQ == 2'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised while fully masked");
endmodule

bind fspc_top fspc_top_props #(
  .FLASH_WORDS(FLASH_WORDS),
  .CFG_WORDS(CFG_WORDS),
  .WP_LIMIT(WP_LIMIT),
  .DEVICE_ID(DEVICE_ID)
) u_props (
  .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .resetDuringWrite(resetDuringWrite), .irq(irq)
);

// ===== tb/tb_fspc_top.sv
`timescale 1ns/10ps
module tb_fspc_top;
  import fspc_pkg::*;
  localparam logic [13:0] TB_DEV_ID = 14'h2A5C; // Arbitrary value
  logic        clk_sys, rst, clkEn, cyc, stb, we, rdw, irq, ackO;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI, datO;
  logic [7:0]  q, r;
  logic [13:0] w, v;
  int          errTotal, samplesChecked, cycles, i;

  fspc_top #(.WP_LIMIT(16), .DEVICE_ID(TB_DEV_ID)) dut (
    .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO),
    .ack_o(ackO), .resetDuringWrite(rdw), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] adrHighExp(input logic [7:0] d);
    return {1'b1, d[6:0]};
  endfunction

  task automatic wrap_up();
    if (errTotal == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang here is cut by the cycle ceiling
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wbCycle(input logic w1, input logic [4:0] a, input logic [7:0] d,
                         output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w1;
    adr <= a;
    datI <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ackO !== 1'b1 && n < 50);
    rd = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wrReg(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    wbCycle(1'b1, a, d, dummy);
  endtask

  task automatic rdReg(input logic [4:0] a, output logic [7:0] d);
    wbCycle(1'b0, a, 8'h00, d);
  endtask

  task automatic startOp(input logic [7:0] ctl);
    wrReg(FSPC_OFS_UNLOCK, FSPC_KEY_FIRST);
    wrReg(FSPC_OFS_UNLOCK, FSPC_KEY_SECOND);
    wrReg(FSPC_OFS_CONTROL, ctl);
  endtask

  task automatic waitIdle(output logic [7:0] c);
    int n;
    n = 0;
    do begin
      rdReg(FSPC_OFS_CONTROL, c);
      n++;
    end while (c[FSPC_CTL_WR] === 1'b1 && n < 100);
  endtask

  task automatic readWord(input logic [14:0] a, input logic regs, output logic [13:0] wd);
    logic [7:0] lo;
    logic [7:0] hi;
    wrReg(FSPC_OFS_ADDR_LOW, a[7:0]);
    wrReg(FSPC_OFS_ADDR_HIGH, {1'b0, a[14:8]});
    wrReg(FSPC_OFS_CONTROL, {1'b0, regs, 6'h01});
    repeat (2) @(posedge clk_sys);
    rdReg(FSPC_OFS_CONTROL, lo);
    check("read start", 16'h0000, {15'h0, lo[FSPC_CTL_RD]});
    rdReg(FSPC_OFS_DATA_LOW, lo);
    rdReg(FSPC_OFS_DATA_HIGH, hi);
    wd = {hi[5:0], lo};
  endtask

  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    {cyc, stb, we, rdw} = 4'h0;
    adr = 5'h00;
    sel = 4'hF;
    datI = 32'h0000_0000;
    {errTotal, samplesChecked, cycles} = {32'd0, 32'd0, 32'd0};
    void'($urandom(55));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdReg(FSPC_OFS_ADDR_LOW, q);
    check("addr low reset", 16'h0000, {8'h00, q});
    rdReg(FSPC_OFS_ADDR_HIGH, q);
    check("addr high reset", 16'h0080, {8'h00, q});
    for (i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'hFF : 8'($urandom);
      wrReg(FSPC_OFS_DATA_LOW, r);
      rdReg(FSPC_OFS_DATA_LOW, q);
      check("data low", {8'h00, r}, {8'h00, q});
      wrReg(FSPC_OFS_DATA_HIGH, r);
      rdReg(FSPC_OFS_DATA_HIGH, q);
      check("data high", {10'h000, r[5:0]}, {8'h00, q});
      wrReg(FSPC_OFS_ADDR_HIGH, r);
      rdReg(FSPC_OFS_ADDR_HIGH, q);
      check("addr high", {8'h00, adrHighExp(r)}, {8'h00, q});
    end
    // Key broken by another write must not arm a start
    wrReg(FSPC_OFS_ADDR_HIGH, 8'h00);
    wrReg(FSPC_OFS_CONTROL, 8'h04);
    wrReg(FSPC_OFS_UNLOCK, FSPC_KEY_FIRST);
    wrReg(FSPC_OFS_ADDR_LOW, 8'h45);
    wrReg(FSPC_OFS_UNLOCK, FSPC_KEY_SECOND);
    // Keep the error bit written as one so the start attempt cannot clear it
    wrReg(FSPC_OFS_CONTROL, 8'h0E);
    rdReg(FSPC_OFS_CONTROL, q);
    check("broken key", 16'h0008, {8'h00, q & 8'h0A});
    wrReg(FSPC_OFS_CONTROL, 8'h04);
    rdReg(FSPC_OFS_IRQ_STATUS, q);
    wrReg(FSPC_OFS_IRQ_MASK, 8'h00);
    startOp(8'h16);
    wrReg(FSPC_OFS_CONTROL, 8'h14);
    rdReg(FSPC_OFS_CONTROL, q);
    check("erase busy", 16'h0016, {8'h00, q});
    waitIdle(q);
    check("erase end", 16'h0004, {8'h00, q});
    #1 check("irq masked", 16'h0000, {15'h0, irq});
    wrReg(FSPC_OFS_IRQ_MASK, 8'h01);
    #1 check("irq raised", 16'h0001, {15'h0, irq});
    rdReg(FSPC_OFS_IRQ_STATUS, q);
    check("status done", 16'h0001, {8'h00, q});
    #1 check("irq cleared", 16'h0000, {15'h0, irq});
    readWord(15'h0045, 1'b0, v);
    check("erased word", {2'b00, FSPC_BLANK_WORD}, {2'b00, v});
    w = 14'($urandom);
    wrReg(FSPC_OFS_CONTROL, 8'h24);
    wrReg(FSPC_OFS_DATA_LOW, w[7:0]);
    wrReg(FSPC_OFS_DATA_HIGH, {2'b00, w[13:8]});
    startOp(8'h26);
    wrReg(FSPC_OFS_CONTROL, 8'h04);
    startOp(8'h06);
    waitIdle(q);
    readWord(15'h0045, 1'b0, v);
    check("programmed word", {2'b00, w}, {2'b00, v});
    readWord(15'h0046, 1'b0, v);
    check("unloaded latch", {2'b00, FSPC_BLANK_WORD}, {2'b00, v});
    readWord(15'h0005, 1'b1, v);
    check("device id", {2'b00, TB_DEV_ID}, {2'b00, v});
    readWord(15'h0020, 1'b1, v);
    check("outside window", 16'h0000, {2'b00, v});
    // Protected word: start refused with error
    readWord(15'h0008, 1'b0, v);
    wrReg(FSPC_OFS_CONTROL, 8'h14);
    startOp(8'h16);
    waitIdle(q);
    check("protected", 16'h0008, {8'h00, q & 8'h0A});
    wrReg(FSPC_OFS_CONTROL, 8'h14);
    wrReg(FSPC_OFS_ADDR_LOW, 8'h80);
    startOp(8'h16);
    rdw <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdw <= 1'b0;
    waitIdle(q);
    check("reset in write", 16'h0008, {8'h00, q & 8'h08});
    wrap_up();
  end
endmodule
